// [hw/cmp_pkg.sv]
// Constants and types for the charger mode and protection controller.
// Assumes a single 100 MHz system clock and synchronous active-low reset.
package cmp_pkg;
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned WAKE_US         = 500;
  localparam int unsigned INT_PULSE_US    = 256;
  localparam int unsigned WDT_WAIT_MS     = 32;
  localparam int unsigned OVP_DEG_SHORT_MS = 21;
  localparam int unsigned OVP_DEG_LONG_MS  = 100;
  localparam int unsigned WAKE_CYC     = WAKE_US * CLK_MHZ;
  localparam int unsigned INT_CYC      = INT_PULSE_US * CLK_MHZ;
  localparam int unsigned WAIT_CYC     = WDT_WAIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEG_SHORT_CYC = OVP_DEG_SHORT_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEG_LONG_CYC  = OVP_DEG_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W        = 24;
  localparam int unsigned HIC_UNIT_CYC = 100000; // One off-time step, 1 ms
  localparam int unsigned WDT_PERIOD_CYC = 100000000; // Default watchdog period, 1 s
  // Protection event indices
  localparam int unsigned NPROT    = 9;
  localparam int unsigned P_VOUT_OV = 0;
  localparam int unsigned P_VBUS_OV = 1;
  localparam int unsigned P_IBUS_OC = 2;
  localparam int unsigned P_REV_OC  = 3;
  localparam int unsigned P_SHORT   = 4;
  localparam int unsigned P_OTP     = 5;
  localparam int unsigned P_CFLY    = 6;
  localparam int unsigned P_CON_OC  = 7;
  localparam int unsigned P_LOWIN   = 8;
  localparam logic [1:0] FET_OFF = 2'h0;
  typedef enum logic [2:0] {
    CMP_PRESENT = 3'b000,
    CMP_STANDBY = 3'b001,
    CMP_BYPASS  = 3'b010,
    CMP_REVBYP  = 3'b011,
    CMP_HALVE   = 3'b100,
    CMP_REVHALF = 3'b101
  } cmp_mode_t;
endpackage

// [hw/cmp_wdt.sv]
// Watchdog timer with interrupt pulse and delayed register reset.
// Assumes the host access strobe is one cycle per register access.
`timescale 1ns/1ps
module cmp_wdt #(
  parameter int unsigned PERIOD_CYC = cmp_pkg::WDT_PERIOD_CYC,
  parameter int unsigned INT_CYC    = cmp_pkg::INT_CYC,
  parameter int unsigned WAIT_CYC   = cmp_pkg::WAIT_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_enable,
  input  wire logic i_access,
  input  wire logic i_flag_clr,
  output logic      o_status,
  output logic      o_flag,
  output logic      o_int_req,
  output logic      o_reg_reset
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [31:0] pcnt;
    logic [31:0] wcnt;
    logic        stat;
    logic        flag;
    logic        pulse;
    logic        waiting;
    logic        rreset;
  } cmp_wdt_st_t;
  cmp_wdt_st_t st, next_st;

  // Count, expire, pulse, then wait for reset of defaults
  always_comb begin
    next_st        = st;
    next_st.rreset = 1'b0;
    if (i_flag_clr) begin
      next_st.flag = 1'b0;
    end
    if (i_access) begin
      next_st.cnt     = '0;
      next_st.stat    = 1'b0;
      next_st.waiting = 1'b0;
    end else if (i_enable && !st.stat) begin
      if (st.cnt == PERIOD_CYC - 1) begin
        next_st.stat    = 1'b1;
        next_st.flag    = 1'b1;
        next_st.pulse   = 1'b1;
        next_st.pcnt    = '0;
        next_st.waiting = 1'b1;
        next_st.wcnt    = '0;
      end else begin
        next_st.cnt = st.cnt + 32'h1;
      end
    end
    if (st.pulse) begin
      next_st.pcnt = st.pcnt + 32'h1;
      if (st.pcnt == INT_CYC - 1) begin
        next_st.pulse = 1'b0;
      end
    end
    if (st.waiting && !i_access) begin
      next_st.wcnt = st.wcnt + 32'h1;
      if (st.wcnt == WAIT_CYC - 1) begin
        next_st.waiting = 1'b0;
        next_st.rreset  = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_status    = st.stat;
  assign o_flag      = st.flag;
  assign o_int_req   = st.pulse;
  assign o_reg_reset = st.rreset;

  pulse_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(st.pulse) |-> st.pulse [*8]) else $error("Interrupt pulse too short");
  expire_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(st.stat) |-> st.flag && st.pulse) else $error("Expiry without flag");
endmodule

// [hw/cmp_ctrl.sv]
// Top of the charger mode and protection controller.
// Assumes protection inputs are deglitched single-cycle level detections in sync with i_clk_sys.
`timescale 1ns/1ps
module cmp_ctrl #(
  parameter int unsigned WAKE_CYC      = cmp_pkg::WAKE_CYC,
  parameter int unsigned WDT_CYC       = cmp_pkg::WDT_PERIOD_CYC,
  parameter int unsigned INT_CYC       = cmp_pkg::INT_CYC,
  parameter int unsigned WAIT_CYC      = cmp_pkg::WAIT_CYC,
  parameter int unsigned DEG_SHORT_CYC = cmp_pkg::DEG_SHORT_CYC,
  parameter int unsigned DEG_LONG_CYC  = cmp_pkg::DEG_LONG_CYC,
  parameter int unsigned HIC_UNIT_CYC  = cmp_pkg::HIC_UNIT_CYC
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_supply_good,
  input  wire logic                       i_addr_select,
  input  wire logic                       i_enable_n,
  input  wire logic                       i_host_access,
  input  wire logic                       i_host_write,
  input  wire logic                       i_wr_charge_enable,
  input  wire logic                       i_wr_divider_mode_select,
  input  wire logic                       i_wr_reverse_enable,
  input  wire logic [1:0]                 i_wr_blocking_fet_control,
  input  wire logic                       i_overvoltage_auto_restart,
  input  wire logic                       i_restart_deglitch_select,
  input  wire logic [1:0]                 i_short_off_time,
  input  wire logic                       i_wireless_good_in_low_power,
  input  wire logic                       i_wireless_good_enable,
  input  wire logic                       i_wireless_input_good_raw,
  input  wire logic                       i_input_present,
  input  wire logic                       i_soft_start_done,
  input  wire logic [cmp_pkg::NPROT-1:0]  i_prot_event,
  input  wire logic [cmp_pkg::NPROT-1:0]  i_flag_clr,
  input  wire logic                       i_watchdog_timeout_flag_clr,
  output logic                            o_bus_ready,
  output logic                            o_addr_config,
  output logic                            o_charge_enable_bit,
  output logic                            o_divider_mode_select,
  output logic                            o_reverse_enable,
  output logic [1:0]                      o_blocking_fet_control,
  output logic [2:0]                      o_mode,
  output logic                            o_converter_run,
  output logic                            o_wireless_input_good,
  output logic [cmp_pkg::NPROT-1:0]       o_prot_flag,
  output logic                            o_watchdog_timeout_status,
  output logic                            o_watchdog_timeout_flag,
  output logic                            o_int_n,
  output logic                            o_int_oe
);
  typedef struct packed {
    logic [31:0]               wake_cnt;
    logic                      ready;
    logic                      addr;
    logic                      chg;
    logic                      msel;
    logic                      rev;
    logic [1:0]                fet;
    logic                      ovp_stop;
    logic [31:0]               deg_cnt;
    logic                      hic_stop;
    logic [31:0]               hic_cnt;
    logic                      running;
    logic [cmp_pkg::NPROT-1:0] flags;
    logic                      evt_int;
  } cmp_st_t;
  cmp_st_t st, next_st;

  logic             wdt_status;
  logic             watchdog_timeout_flag;
  logic             wdt_int;
  logic             wdt_reg_reset;
  logic             access_ok;
  cmp_pkg::cmp_mode_t mode;
  logic             prot_on;
  logic             lowin_ok;
  logic             fet_on;
  logic [cmp_pkg::NPROT-1:0] ev;

  // Only accesses after address detection reach the registers
  assign access_ok = i_host_access && st.ready;

  cmp_wdt #(
    .PERIOD_CYC (WDT_CYC),
    .INT_CYC    (INT_CYC),
    .WAIT_CYC   (WAIT_CYC)
  ) u_wdt (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_enable    (st.ready),
    .i_access    (access_ok),
    .i_flag_clr  (i_watchdog_timeout_flag_clr && access_ok),
    .o_status    (wdt_status),
    .o_flag      (watchdog_timeout_flag),
    .o_int_req   (wdt_int),
    .o_reg_reset (wdt_reg_reset)
  );

  // Mode decode from enable pin and control bits
  always_comb begin
    if (i_enable_n) begin
      mode = cmp_pkg::CMP_PRESENT;
    end else if (!st.chg) begin
      mode = cmp_pkg::CMP_STANDBY;
    end else begin
      unique case ({st.msel, st.rev})
        2'b00: mode = cmp_pkg::CMP_BYPASS;
        2'b01: mode = cmp_pkg::CMP_REVBYP;
        2'b10: mode = cmp_pkg::CMP_HALVE;
        2'b11: mode = cmp_pkg::CMP_REVHALF;
      endcase
    end
  end

  assign prot_on = (mode != cmp_pkg::CMP_PRESENT);
  assign fet_on  = st.fet[1];
  // Events only count where their check is active
  always_comb begin
    ev = prot_on ? i_prot_event : '0;
    ev[cmp_pkg::P_REV_OC] = ev[cmp_pkg::P_REV_OC] && fet_on;
    ev[cmp_pkg::P_LOWIN]  = ev[cmp_pkg::P_LOWIN] && !st.running;
    if (mode == cmp_pkg::CMP_BYPASS) begin
      ev[cmp_pkg::P_CFLY] = 1'b0;
    end
    if (mode == cmp_pkg::CMP_REVBYP) begin
      ev[cmp_pkg::P_SHORT] = 1'b0;
      ev[cmp_pkg::P_CFLY]  = 1'b0;
    end
    if (mode == cmp_pkg::CMP_REVHALF) begin
      ev[cmp_pkg::P_SHORT] = 1'b0;
    end
  end

  // Low-input status level needed depends on direction
  assign lowin_ok = (st.rev ? i_prot_event[cmp_pkg::P_LOWIN]
                            : !i_prot_event[cmp_pkg::P_LOWIN]);

  // Register update, protection responses and soft-start gating
  always_comb begin
    logic ov;
    logic cur;
    ov      = ev[cmp_pkg::P_VOUT_OV] || ev[cmp_pkg::P_VBUS_OV];
    cur     = ev[cmp_pkg::P_IBUS_OC] || ev[cmp_pkg::P_CON_OC];
    next_st = st;
    if (!st.ready) begin
      next_st.wake_cnt = st.wake_cnt + 32'h1;
      if (i_supply_good && st.wake_cnt == WAKE_CYC - 1) begin
        next_st.ready = 1'b1;
        next_st.addr  = i_addr_select;
      end
      if (!i_supply_good) begin
        next_st.wake_cnt = '0;
      end
    end
    // Host writes are accepted in any mode once ready
    if (access_ok && i_host_write) begin
      next_st.chg  = i_wr_charge_enable;
      next_st.msel = i_wr_divider_mode_select;
      next_st.rev  = i_wr_reverse_enable;
      next_st.fet  = i_wr_blocking_fet_control;
    end
    if (wdt_reg_reset) begin
      next_st.chg  = 1'b0;
      next_st.msel = 1'b0;
      next_st.rev  = 1'b0;
      next_st.fet  = cmp_pkg::FET_OFF;
    end
    if (ev[cmp_pkg::P_REV_OC]) begin
      next_st.fet = cmp_pkg::FET_OFF;
    end
    unique case (mode)
      cmp_pkg::CMP_BYPASS: begin
        if (ov) begin
          if (!i_overvoltage_auto_restart) begin
            next_st.chg = 1'b0;
          end else begin
            next_st.ovp_stop = 1'b1;
            next_st.deg_cnt  = '0;
          end
        end
        if (ev[cmp_pkg::P_OTP]) begin
          next_st.chg = 1'b0;
        end
        if (ev[cmp_pkg::P_SHORT]) begin
          next_st.hic_stop = 1'b1;
          next_st.hic_cnt  = '0;
        end
      end
      cmp_pkg::CMP_REVBYP, cmp_pkg::CMP_REVHALF: begin
        if (cur || ev[cmp_pkg::P_OTP]) begin
          next_st.chg = 1'b0;
          next_st.rev = 1'b0;
        end
        if (ov || ev[cmp_pkg::P_CFLY]) begin
          next_st.chg = 1'b0;
        end
      end
      cmp_pkg::CMP_HALVE: begin
        if (ov || cur || ev[cmp_pkg::P_SHORT] || ev[cmp_pkg::P_OTP] || ev[cmp_pkg::P_CFLY]) begin
          next_st.chg = 1'b0;
        end
      end
      default: begin
      end
    endcase
    // Over-voltage restart deglitch counts only while the fault stays away
    if (st.ovp_stop && !ov) begin
      next_st.deg_cnt = st.deg_cnt + 32'h1;
      if (st.deg_cnt == (i_restart_deglitch_select ? DEG_LONG_CYC : DEG_SHORT_CYC) - 1) begin
        next_st.ovp_stop = 1'b0;
      end
    end
    // Hiccup off interval, one unit per off-time step plus one
    if (st.hic_stop && !ev[cmp_pkg::P_SHORT]) begin
      next_st.hic_cnt = st.hic_cnt + 32'h1;
      if (st.hic_cnt == HIC_UNIT_CYC * ({30'h0, i_short_off_time} + 32'h1) - 1) begin
        next_st.hic_stop = 1'b0;
      end
    end
    if (mode != cmp_pkg::CMP_BYPASS) begin
      next_st.ovp_stop = 1'b0;
      next_st.hic_stop = 1'b0;
    end
    // Stop-charge leaves the enable bit; conversion restarts when allowed
    if (!(mode inside {cmp_pkg::CMP_BYPASS, cmp_pkg::CMP_REVBYP,
                       cmp_pkg::CMP_HALVE, cmp_pkg::CMP_REVHALF}) || !next_st.chg ||
        cur && mode == cmp_pkg::CMP_BYPASS || next_st.ovp_stop || next_st.hic_stop) begin
      next_st.running = 1'b0;
    end else if (!st.running && i_input_present && lowin_ok && i_soft_start_done) begin
      next_st.running = 1'b1;
    end
    // Sticky flags: a new trip wins over a host clear
    next_st.flags   = (st.flags & ~(i_flag_clr & {cmp_pkg::NPROT{access_ok}})) | ev;
    next_st.evt_int = (mode != cmp_pkg::CMP_PRESENT) && (|ev);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_bus_ready               = st.ready;
  assign o_addr_config             = st.addr;
  assign o_charge_enable_bit       = st.chg;
  assign o_divider_mode_select     = st.msel;
  assign o_reverse_enable          = st.rev;
  assign o_blocking_fet_control    = st.fet;
  assign o_mode                    = mode;
  assign o_converter_run           = st.running;
  assign o_prot_flag               = st.flags;
  assign o_watchdog_timeout_status = wdt_status;
  assign o_watchdog_timeout_flag   = watchdog_timeout_flag;
  // Wireless-good gating differs only in present mode
  assign o_wireless_input_good = i_wireless_input_good_raw &&
    (mode != cmp_pkg::CMP_PRESENT || (i_wireless_good_in_low_power && i_wireless_good_enable));
  // Open-drain interrupt: drive low only
  assign o_int_n  = 1'b0;
  assign o_int_oe = wdt_int || st.evt_int;

  sequence rev_trip_s;
    mode == cmp_pkg::CMP_REVBYP && i_prot_event[cmp_pkg::P_OTP];
  endsequence
  rev_otp_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    rev_trip_s |=> !st.chg && !st.rev) else $error("Reverse trip kept bits");
  fet_trip_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ev[cmp_pkg::P_REV_OC] |=> st.fet == cmp_pkg::FET_OFF) else $error("FET not forced off");
  halve_cut_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode == cmp_pkg::CMP_HALVE && ev[cmp_pkg::P_CFLY] |=> !st.chg) else $error("Halving trip kept enable");
  byp_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode == cmp_pkg::CMP_BYPASS && ev[cmp_pkg::P_IBUS_OC] && !access_ok |=> st.chg && !st.running)
    else $error("Stop-charge wrong");
  flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    |ev |=> |st.flags) else $error("Trip left no flag");
  present_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode == cmp_pkg::CMP_PRESENT |-> ev == '0) else $error("Protection active in present");
  wake_lock_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !st.ready |=> !st.chg) else $error("Access before wake");
  ovp_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode == cmp_pkg::CMP_BYPASS && ev[cmp_pkg::P_VBUS_OV] && !i_overvoltage_auto_restart && !access_ok
    |=> !st.chg) else $error("Bypass OVP kept enable");
endmodule

// [testbench/cmp_host.sv]
// Host processor model: one-cycle register accesses on the strobe port.
// Assumes the bench calls its task; launches happen at the falling edge.
`timescale 1ns/1ps
module cmp_host (
  input  wire logic       i_clk_sys,
  input  wire logic       i_bus_ready,
  output logic            o_access,
  output logic            o_write,
  output logic [4:0]      o_data
);
  initial begin
    o_access = 1'b0;
    o_write  = 1'b0;
    o_data   = 5'h00;
  end

  // Data is {fet[1:0], reverse, mode select, charge}; early skips the wake wait
  task automatic access(input logic early, input logic wr, input logic [4:0] d);
    int n;
    n = 0;
    while (!early && i_bus_ready !== 1'b1 && n < 1000) begin
      @(negedge i_clk_sys);
      n++;
    end
    @(negedge i_clk_sys);
    o_access = 1'b1;
    o_write  = wr;
    o_data   = d;
    @(negedge i_clk_sys);
    o_access = 1'b0;
    o_data   = ~d; // Released data must not look valid
  endtask
endmodule

// [testbench/test_charger_mode_protection_control.sv]
// Self-checking bench for the charger mode and protection controller.
// Assumes shortened counts: wake 20, watchdog 200, pulse 16, wait 50, deglitch 30/60.
`timescale 1ns/1ps
module test_charger_mode_protection_control;
  logic       clk = 1'b0, rst_n = 1'b0, sup = 1'b0, adr = 1'b0, en_n = 1'b1;
  logic       auto_r = 1'b0, dsel = 1'b0, lp = 1'b0, wen = 1'b0, raw = 1'b0;
  logic       pres = 1'b0, ssd = 1'b0, acc, wr;
  logic [4:0] d;
  logic [8:0] ev = 9'h000, fclr = 9'h000, pflag;
  logic       ready, acfg, chg, msel, rev, run, wg, st, fl, int_n, int_oe;
  logic [1:0] fet;
  logic [2:0] mode;
  logic [31:0] seed = 32'h5E2E0338, r;
  int         mismatches = 0, check_count = 0, cycles = 0, n;
  int         exp_trip_ev[7] = '{0, 1, 2, 4, 5, 6, 7};
  logic [1:0] offt = 2'h0;
  logic       wclr = 1'b0;

  always #5 clk = ~clk;

  cmp_host host (.i_clk_sys(clk), .i_bus_ready(ready), .o_access(acc), .o_write(wr), .o_data(d));

  cmp_ctrl #(.WAKE_CYC(20), .WDT_CYC(200), .INT_CYC(16), .WAIT_CYC(50), .DEG_SHORT_CYC(30),
             .DEG_LONG_CYC(60), .HIC_UNIT_CYC(10)) DUT (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_supply_good(sup), .i_addr_select(adr), .i_enable_n(en_n),
    .i_host_access(acc), .i_host_write(wr), .i_wr_charge_enable(d[0]), .i_wr_divider_mode_select(d[1]),
    .i_wr_reverse_enable(d[2]), .i_wr_blocking_fet_control(d[4:3]), .i_overvoltage_auto_restart(auto_r),
    .i_restart_deglitch_select(dsel), .i_short_off_time(offt), .i_wireless_good_in_low_power(lp),
    .i_wireless_good_enable(wen), .i_wireless_input_good_raw(raw), .i_input_present(pres),
    .i_soft_start_done(ssd), .i_prot_event(ev), .i_flag_clr(fclr), .i_watchdog_timeout_flag_clr(wclr),
    .o_bus_ready(ready), .o_addr_config(acfg), .o_charge_enable_bit(chg), .o_divider_mode_select(msel),
    .o_reverse_enable(rev), .o_blocking_fet_control(fet), .o_mode(mode), .o_converter_run(run),
    .o_wireless_input_good(wg), .o_prot_flag(pflag), .o_watchdog_timeout_status(st),
    .o_watchdog_timeout_flag(fl), .o_int_n(int_n), .o_int_oe(int_oe));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected {charge, reverse, flag} after one trip with auto restart off
  function automatic logic [2:0] exp_trip(input int m, input int e);
    logic ov, cur;
    ov  = (e < 2);
    cur = (e == 2 || e == 5 || e == 7);
    case (m)
      0: return (e == 6) ? 3'h4 : (e == 5 || ov) ? 3'h1 : 3'h5;
      1: return cur ? 3'h1 : ov ? 3'h3 : 3'h6;
      2: return 3'h1;
      default: return cur ? 3'h1 : (e == 4) ? 3'h6 : 3'h3;
    endcase
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic pulse(input int e);
    @(negedge clk);
    ev[e] = 1'b1;
    @(negedge clk);
    ev[e] = 1'b0;
  endtask

  task automatic conclude();
    $display("mismatches=%0d checks=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 30000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    r = xs();
    adr = r[0];
    cyc(16);
    rst_n = 1'b1;
    host.access(1'b1, 1'b1, 5'h01);
    cyc(2);
    check(chg, 1'b0);
    sup = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    check(n >= 19 && n <= 21, 1'b1);
    check(acfg, adr);
    en_n = 1'b0;
    // Mode decode: all enabled-low combinations, then random ones
    for (int i = 0; i < 16; i++) begin
      r = (i < 8) ? {28'h0, i[2:0], 1'b0} : xs();
      en_n = r[0];
      {lp, wen, raw} = r[6:4];
      host.access(1'b0, 1'b1, {2'h0, r[3:1]});
      cyc(1);
      check(mode, r[0] ? 3'h0 : !r[1] ? 3'h1 : 3'h2 + 3'(2 * r[2]) + 3'(r[3]));
      check(msel, r[2]);
      if (r[0])
        check(wg, lp & wen & raw);
    end
    // Present mode ignores trips; standby reports them on the pin
    en_n = 1'b1;
    fclr = 9'h1FF;
    host.access(1'b0, 1'b1, 5'h00);
    fclr = 9'h000;
    pulse(2);
    cyc(2);
    check(pflag, 9'h000);
    en_n = 1'b0;
    pulse(5);
    n = 0;
    while (int_oe !== 1'b1 && n < 4) begin
      cyc(1);
      n++;
    end
    check(int_oe, 1'b1);
    check(int_n, 1'b0);
    check(pflag[5], 1'b1);
    // Every trip except reverse over-current and low input, in every charging mode
    for (int m = 0; m < 4; m++)
      foreach (exp_trip_ev[k]) begin
        fclr = 9'h1FF;
        host.access(1'b0, 1'b1, {2'h0, m[0], m[1], 1'b1});
        fclr = 9'h000;
        pulse(exp_trip_ev[k]);
        cyc(2);
        check({chg, rev, pflag[exp_trip_ev[k]]}, exp_trip(m, exp_trip_ev[k]));
      end
    // Soft-start gating by the low-input status and stop-charge restart
    {pres, ssd} = 2'h3;
    host.access(1'b0, 1'b1, 5'h05);
    cyc(5);
    check(run, 1'b0);
    ev[8] = 1'b1;
    cyc(5);
    check(run, 1'b1);
    ev[8] = 1'b0;
    host.access(1'b0, 1'b1, 5'h11);
    cyc(5);
    check({run, fet}, 3'h6);
    pulse(7);
    cyc(5);
    check({run, chg}, 2'h3);
    pulse(3);
    cyc(2);
    check({fet, chg}, 3'h1);
    // Output short hiccup with a random off time
    r = xs();
    offt = r[1:0];
    pulse(4);
    cyc(10 * (offt + 1) - 2);
    check(run, 1'b0);
    cyc(2);
    check(run, 1'b1);
    // Over-voltage restart deglitch in bypass
    auto_r = 1'b1;
    for (int s = 0; s < 2; s++) begin
      dsel = s[0];
      host.access(1'b0, 1'b1, 5'h01);
      ev[1] = 1'b1;
      cyc(5);
      ev[1] = 1'b0;
      cyc(s ? 55 : 25);
      check({run, chg}, 2'h1);
      cyc(15);
      check(run, 1'b1);
    end
    // Watchdog expiry, pulse length and default restore
    host.access(1'b0, 1'b1, 5'h01);
    n = 0;
    while (st !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    check(n >= 198 && n <= 202, 1'b1);
    check(fl, 1'b1);
    n = 0;
    while (int_oe === 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    check(n >= 15 && n <= 17, 1'b1);
    cyc(40);
    check(chg, 1'b0);
    host.access(1'b0, 1'b1, 5'h01);
    n = 0;
    while (st !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    cyc(20);
    host.access(1'b0, 1'b0, 5'h00);
    cyc(45);
    check(chg, 1'b1);
    // Watchdog flag stays until the host clears it
    check(fl, 1'b1);
    wclr = 1'b1;
    host.access(1'b0, 1'b0, 5'h00);
    wclr = 1'b0;
    check(fl, 1'b0);
    conclude();
  end
endmodule
